//--- rtl/accel_data_readout_regs.sv
// six read-only acceleration data registers behind the serial register port
// assumes the serial engine gives one-cycle read and write strobes on ref_clk_i
`default_nettype none
// Summary of operation
// - after a low-byte read, that axis's high byte stays frozen until read
// - freeze only while shadow disable is low; otherwise no consistency
// - low register bits 7:4 carry sample bits 3:0
// - high register carries sample bits 11:4, bit 11 in bit 7
// - low register bits 3:1 carry no meaning; host ignores them
// - low register bit 0 shows an update since the last readout
// - data readable except at power-up and in deep suspend
// - all six registers are read-only; writes change nothing
module accel_data_readout_regs
  import accel_readout_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // conversion results from the measurement path
  input wire logic sample_valid_i,
  input wire accel_sample_t sample_i,
  // control and power state
  input wire logic shadow_dis_i,
  input wire logic data_ready_i,
  // serial register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o
);
  logic [ACC_W-1:0] axis_sample [AXIS_CNT];
  logic [ACC_W-1:0] axis_live [AXIS_CNT];
  logic [7:0] axis_low [AXIS_CNT];
  logic [7:0] axis_high [AXIS_CNT];
  logic [AXIS_CNT-1:0] rd_low;
  logic [AXIS_CNT-1:0] rd_high;
  logic rd_take;
  logic hit;
  logic [7:0] sel_byte;
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic rvalid_r;

  // reads are taken only when data may be served; writes are never taken
  assign rd_take = reg_rd_i && !reg_wr_i && data_ready_i;

  // address decode per axis
  assign axis_sample[0] = sample_i.x;
  assign axis_sample[1] = sample_i.y;
  assign axis_sample[2] = sample_i.z;
  assign rd_low[0] = rd_take && (reg_addr_i == X_LOW_OFF);
  assign rd_low[1] = rd_take && (reg_addr_i == Y_LOW_OFF);
  assign rd_low[2] = rd_take && (reg_addr_i == Z_LOW_OFF);
  assign rd_high[0] = rd_take && (reg_addr_i == X_HIGH_OFF);
  assign rd_high[1] = rd_take && (reg_addr_i == Y_HIGH_OFF);
  assign rd_high[2] = rd_take && (reg_addr_i == Z_HIGH_OFF);
  assign hit = |{rd_low, rd_high};

  // one shadow unit per axis
  for (genvar i = 0; i < AXIS_CNT; i++) begin : g_axis
    axis_shadow u_axis (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .sample_valid_i(sample_valid_i),
      .sample_i(axis_sample[i]),
      .shadow_dis_i(shadow_dis_i),
      .rd_low_i(rd_low[i]),
      .rd_high_i(rd_high[i]),
      .low_byte_o(axis_low[i]),
      .high_byte_o(axis_high[i]),
      .live_o(axis_live[i])
    );
  end

  // read data select; unmapped or refused reads return zero
  assign sel_byte = rd_low[0] ? axis_low[0] :
                    rd_low[1] ? axis_low[1] :
                    rd_low[2] ? axis_low[2] :
                    rd_high[0] ? axis_high[0] :
                    rd_high[1] ? axis_high[1] :
                    axis_high[2];
  assign rdata_nxt = hit ? sel_byte : IDLE_READ;

  // read data register and answer strobe
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_r <= IDLE_READ;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd_i && !reg_wr_i;
      if (reg_rd_i && !reg_wr_i) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  assign reg_rdata_o = rdata_r;
  assign reg_rvalid_o = rvalid_r;

  // checks on layout and access
  chk_low_layout: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    rd_low[1] |=> (reg_rdata_o[7:4] == $past(axis_live[1][3:0])) && reg_rvalid_o)
    else $error("low byte layout wrong");
  chk_high_layout: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (rd_high[2] && !$past(rd_low[2]) && !g_axis[2].u_axis.lock_r)
      |=> (reg_rdata_o == $past(axis_live[2][11:4])))
    else $error("high byte layout wrong");
  chk_undef_bits: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (rd_low[0] || rd_low[2]) |=> (reg_rdata_o[3:1] == UNDEF_FILL))
    else $error("undefined bits not filled");
  chk_burst_match: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (rd_low[0] && !shadow_dis_i) ##1 (rd_high[0] && !rd_low[0])
      |=> (reg_rdata_o == $past(axis_live[0][11:4], 2)))
    else $error("burst high byte does not match low byte");
  chk_refused_read: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (reg_rd_i && !reg_wr_i && !data_ready_i) |=> (reg_rvalid_o && reg_rdata_o == IDLE_READ))
    else $error("read served while data not ready");
  chk_write_ignored: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (reg_wr_i && !sample_valid_i) |=> (axis_live[0] == $past(axis_live[0]) && !reg_rvalid_o))
    else $error("write altered data registers");

  // answer strobe follows every taken or refused read by one cycle
  chk_rvalid_follows: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (reg_rd_i && !reg_wr_i) |=> reg_rvalid_o)
    else $error("read not answered");

  // no answer without a read strobe, writes included
  chk_rvalid_quiet: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !(reg_rd_i && !reg_wr_i) |=> !reg_rvalid_o)
    else $error("answer without read");

  // read data stands until the next read
  chk_rdata_stands: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !(reg_rd_i && !reg_wr_i) |=> $stable(reg_rdata_o))
    else $error("read data moved without read");

  // unmapped addresses answer with the idle byte
  chk_unmapped_zero: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (reg_rd_i && !reg_wr_i && !hit) |=> (reg_rdata_o == IDLE_READ))
    else $error("unmapped read not idle");

  // x low byte carries the sample's low nibble
  chk_low_layout_x: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    rd_low[0] |=> (reg_rdata_o[7:4] == $past(axis_live[0][3:0])))
    else $error("x low byte layout wrong");

  // z low byte carries the sample's low nibble
  chk_low_layout_z: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    rd_low[2] |=> (reg_rdata_o[7:4] == $past(axis_live[2][3:0])))
    else $error("z low byte layout wrong");

  // y undefined bits follow the fill value
  chk_undef_bits_y: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    rd_low[1] |=> (reg_rdata_o[3:1] == UNDEF_FILL))
    else $error("y undefined bits not filled");

  // x high byte shows the live sample when not frozen
  chk_high_open_x: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (rd_high[0] && !g_axis[0].u_axis.lock_r) |=> (reg_rdata_o == $past(axis_live[0][11:4])))
    else $error("x high byte layout wrong");

  // y high byte shows the live sample when not frozen
  chk_high_open_y: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (rd_high[1] && !g_axis[1].u_axis.lock_r) |=> (reg_rdata_o == $past(axis_live[1][11:4])))
    else $error("y high byte layout wrong");

  // new-data flag of x appears in bit zero
  chk_flag_shown_x: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    rd_low[0] |=> (reg_rdata_o[FLAG_BIT] == $past(g_axis[0].u_axis.flag_r)))
    else $error("x flag not shown");

  // new-data flag of y appears in bit zero
  chk_flag_shown_y: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    rd_low[1] |=> (reg_rdata_o[FLAG_BIT] == $past(g_axis[1].u_axis.flag_r)))
    else $error("y flag not shown");

  // new-data flag of z appears in bit zero
  chk_flag_shown_z: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    rd_low[2] |=> (reg_rdata_o[FLAG_BIT] == $past(g_axis[2].u_axis.flag_r)))
    else $error("z flag not shown");

  // y burst returns the high byte that matches the low byte
  chk_burst_match_y: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (rd_low[1] && !shadow_dis_i) ##1 (rd_high[1] && !rd_low[1])
      |=> (reg_rdata_o == $past(axis_live[1][11:4], 2)))
    else $error("y burst high byte does not match");

  // z burst returns the high byte that matches the low byte
  chk_burst_match_z: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (rd_low[2] && !shadow_dis_i) ##1 (rd_high[2] && !rd_low[2])
      |=> (reg_rdata_o == $past(axis_live[2][11:4], 2)))
    else $error("z burst high byte does not match");

  // refused reads and writes leave the x flag alone
  chk_refused_flag_x: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    ((!data_ready_i || reg_wr_i) && !sample_valid_i) |=> $stable(g_axis[0].u_axis.flag_r))
    else $error("x flag touched by refused access");

  // refused reads and writes leave the y flag alone
  chk_refused_flag_y: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    ((!data_ready_i || reg_wr_i) && !sample_valid_i) |=> $stable(g_axis[1].u_axis.flag_r))
    else $error("y flag touched by refused access");

  // refused reads and writes leave the z flag alone
  chk_refused_flag_z: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    ((!data_ready_i || reg_wr_i) && !sample_valid_i) |=> $stable(g_axis[2].u_axis.flag_r))
    else $error("z flag touched by refused access");

  // writes never alter the y sample
  chk_write_keeps_y: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (reg_wr_i && !sample_valid_i) |=> (axis_live[1] == $past(axis_live[1])))
    else $error("write altered y data");

  // writes never alter the z sample
  chk_write_keeps_z: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (reg_wr_i && !sample_valid_i) |=> (axis_live[2] == $past(axis_live[2])))
    else $error("write altered z data");

  // writes never disturb a pending x freeze
  chk_write_keeps_lock: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (reg_wr_i && g_axis[0].u_axis.lock_r) |=> g_axis[0].u_axis.lock_r)
    else $error("write released x freeze");
endmodule
`default_nettype wire

//--- rtl/accel_readout_pkg.sv
// constants and carrier types for the acceleration readout registers
// assumes one 100 MHz clock shared with the serial register engine
`default_nettype none
package accel_readout_pkg;
  // register offsets on the serial register port
  localparam logic [7:0] X_LOW_OFF = 8'h02;
  localparam logic [7:0] X_HIGH_OFF = 8'h03;
  localparam logic [7:0] Y_LOW_OFF = 8'h04;
  localparam logic [7:0] Y_HIGH_OFF = 8'h05;
  localparam logic [7:0] Z_LOW_OFF = 8'h06;
  localparam logic [7:0] Z_HIGH_OFF = 8'h07;
  // geometry of the data registers
  localparam int AXIS_CNT = 3;
  localparam int ACC_W = 12;
  localparam int LOW_DATA_LSB = 4;
  localparam int FLAG_BIT = 0;
  // value driven on the undefined bits and on refused reads
  localparam logic [2:0] UNDEF_FILL = 3'h0;
  localparam logic [7:0] IDLE_READ = 8'h00;
  localparam logic [ACC_W-1:0] SAMPLE_RST = 12'h000;

  // one conversion result for all three axes
  typedef struct packed {
    logic [ACC_W-1:0] z;
    logic [ACC_W-1:0] y;
    logic [ACC_W-1:0] x;
  } accel_sample_t;
endpackage
`default_nettype wire

//--- rtl/axis_shadow.sv
// one axis: live sample, new-data flag and the high-byte freeze
// assumes read strobes are single-cycle pulses on the same clock
`default_nettype none
module axis_shadow
  import accel_readout_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // conversion side
  input wire logic sample_valid_i,
  input wire logic [ACC_W-1:0] sample_i,
  input wire logic shadow_dis_i,
  // read side
  input wire logic rd_low_i,
  input wire logic rd_high_i,
  output logic [7:0] low_byte_o,
  output logic [7:0] high_byte_o,
  output logic [ACC_W-1:0] live_o
);
  logic [ACC_W-1:0] live_r;
  logic [7:0] held_r;
  logic lock_r;
  logic flag_r;
  logic lock_nxt;
  logic flag_nxt;

  // lock opens on low read, closes on high read; set wins over clear
  assign lock_nxt = (rd_low_i && !shadow_dis_i) ? 1'b1 : (rd_high_i ? 1'b0 : lock_r);
  assign flag_nxt = sample_valid_i ? 1'b1 : ((rd_low_i || rd_high_i) ? 1'b0 : flag_r);

  // live sample, frozen high byte and flags
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      live_r <= SAMPLE_RST;
      held_r <= 8'h00;
      lock_r <= 1'b0;
      flag_r <= 1'b0;
    end else begin
      if (sample_valid_i) begin
        live_r <= sample_i;
      end
      if (rd_low_i && !shadow_dis_i) begin
        held_r <= live_r[ACC_W-1:LOW_DATA_LSB];
      end
      lock_r <= lock_nxt;
      flag_r <= flag_nxt;
    end
  end

  // byte views for the read mux
  assign low_byte_o = {live_r[LOW_DATA_LSB-1:0], UNDEF_FILL, flag_r};
  assign high_byte_o = lock_r ? held_r : live_r[ACC_W-1:LOW_DATA_LSB];
  assign live_o = live_r;

  // checks on freeze and flag
  chk_high_frozen: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (lock_r && !rd_high_i && !rd_low_i) |=> (high_byte_o == $past(high_byte_o)))
    else $error("high byte moved while frozen");
  chk_freeze_needs_enable: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!lock_r && rd_low_i && shadow_dis_i) |=> !lock_r)
    else $error("freeze applied with shadowing disabled");
  chk_freeze_starts: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (rd_low_i && !shadow_dis_i && !sample_valid_i) ##1 (!rd_high_i && sample_valid_i)
      |=> (high_byte_o == $past(held_r, 1)) && lock_r)
    else $error("freeze did not start on low read");
  chk_flag_sets: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    sample_valid_i |=> (flag_r && live_r == $past(sample_i)))
    else $error("new sample not flagged");
  chk_flag_clears: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    ((rd_low_i || rd_high_i) && !sample_valid_i) |=> !low_byte_o[FLAG_BIT])
    else $error("flag not cleared by readout");
endmodule
`default_nettype wire

//--- dv/host_model.sv
// host side model: issues register reads and writes
// assumes the answer lands one cycle after a taken strobe
`default_nettype none
module host_model (
  // clock and answer
  input wire logic clk_i,
  input wire logic rvalid_i,
  input wire logic [7:0] rdata_i,
  // strobes
  output logic [7:0] addr_o,
  output logic rd_o,
  output logic wr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle port
  initial begin
    addr_o = 8'h00;
    rd_o = 1'b0;
    wr_o = 1'b0;
  end
  // single read, answer taken with rvalid
  task automatic rd1(input logic [7:0] a, output logic [8:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_i);
    d = {rvalid_i, rdata_i};
  endtask
  // burst of low then high byte
  task automatic rd2(input logic [7:0] a, output logic [8:0] lo, output logic [8:0] hi);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    addr_o <= a + 8'h01;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    lo = {rvalid_i, rdata_i};
    @(posedge clk_i);
    hi = {rvalid_i, rdata_i};
  endtask
  // write strobe with no data
  task automatic wr1(input logic [7:0] a);
    @(posedge clk_i);
    addr_o <= a;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- dv/accel_data_readout_regs_tb.sv
// bench for the acceleration readout registers
// assumes host_model drives the register port
`default_nettype none
module accel_data_readout_regs_tb;
  import accel_readout_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [11:0] v;} row_t;
  logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, sample_valid_i = 1'b0;
  logic shadow_dis_i = 1'b0, data_ready_i = 1'b1, rvalid, rd, wr;
  logic [7:0] rdata, addr;
  logic [8:0] lo, hi;
  accel_sample_t sample_i = '0;
  int fails = 0, total_checks = 0, cyc = 0;
  row_t rows[3] = '{'{8'h02, 12'habc}, '{8'h04, 12'h123}, '{8'h06, 12'hf05}};
  // clock
  always #5 ref_clk_i = ~ref_clk_i;
  accel_data_readout_regs u_dut (.ref_clk_i, .sys_rst_i, .sample_valid_i, .sample_i,
    .shadow_dis_i, .data_ready_i, .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid));
  host_model u_host (.clk_i(ref_clk_i), .rvalid_i(rvalid), .rdata_i(rdata),
    .addr_o(addr), .rd_o(rd), .wr_o(wr));
  task automatic chk(string n, logic [8:0] got, logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic put(logic [35:0] s);
    @(posedge ref_clk_i);
    sample_valid_i <= 1'b1;
    sample_i <= s;
    @(posedge ref_clk_i);
    sample_valid_i <= 1'b0;
  endtask
  // hang guard
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      tally_and_finish();
    end
  end
  // main sequence; low bits 3:1 masked off
  initial begin
    repeat (8) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    put({12'hf05, 12'h123, 12'habc});
    foreach (rows[i]) begin
      u_host.rd2(rows[i].a, lo, hi);
      chk("low", lo & 9'h1f1, {1'b1, rows[i].v[3:0], 4'h1});
      chk("high", hi, {1'b1, rows[i].v[11:4]});
      u_host.rd1(rows[i].a, lo);
      chk("flag", lo & 9'h101, 9'h100);
    end
    // fresh sample between low and high read
    u_host.rd1(8'h02, lo);
    put({24'h0, 12'h5a7});
    u_host.rd1(8'h03, hi);
    chk("frozen", hi, 9'h1ab);
    u_host.rd1(8'h02, lo);
    chk("new low", lo & 9'h1f1, 9'h170);
    u_host.rd1(8'h03, hi);
    chk("released", hi, 9'h15a);
    // sample lands the cycle after a low read; freeze keeps the old high byte
    fork
      u_host.rd1(8'h06, lo);
      begin
        @(posedge ref_clk_i);
        put({12'h9e1, 24'h0});
      end
    join
    chk("late low", lo & 9'h1f1, 9'h101);
    u_host.rd1(8'h07, hi);
    chk("late frozen", hi, 9'h100);
    u_host.rd1(8'h07, hi);
    chk("late open", hi, 9'h19e);
    @(posedge ref_clk_i);
    shadow_dis_i <= 1'b1;
    u_host.rd1(8'h02, lo);
    put({24'h0, 12'h3c0});
    u_host.rd1(8'h03, hi);
    chk("no freeze", hi, 9'h13c);
    u_host.wr1(8'h03);
    u_host.rd1(8'h03, hi);
    chk("write", hi, 9'h13c);
    u_host.rd1(8'h09, hi);
    chk("unmapped", hi, 9'h100);
    @(posedge ref_clk_i);
    data_ready_i <= 1'b0;
    u_host.rd1(8'h03, hi);
    chk("asleep", hi, 9'h100);
    @(posedge ref_clk_i);
    data_ready_i <= 1'b1;
    sys_rst_i <= 1'b1;
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    u_host.rd1(8'h03, hi);
    chk("reset", hi, 9'h100);
    tally_and_finish();
  end
endmodule
`default_nettype wire
